// ==== src/uss_slave.sv ====
// Sync slave serial port: Avalon-MM registers on core_clk_in, shifting on the link clock.
// Notes on behaviour
// - Slave takes shift clock from master, never generates.
// - Transfers continue while core sleeps.
// - Two queued words: first shifts, second held.
// - Second word loads when first done, flag sets.
// - Transmit flag with enable raises wake interrupt.
// - Software sets mode bits, clears continuous receive.
// - Ninth transmit bit sent when option set.
// - Software loads holding register before enabling transmit.
// - Single-receive enable ignored in slave mode.
// - Continuous receive captures word into buffer, flags.
// - Receive flag with enable raises wake interrupt.
// - Ninth receive bit captured, read in status.
// - Received 8-bit word read from receive buffer.
// - Error stays until continuous receive or serial port enable cleared.
// - Clearing enables aborts reception, resets receive logic.
`timescale 1ns/1ps
`include "uss_regs.svh"
module uss_slave (
  input  wire logic                    core_clk_in,
  input  wire logic                    reset_in,
  input  wire logic [`USS_ADDR_W-1:0]  avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  output logic                         wake_irq_out,
  uss_link_if.device                   link
);
  logic [7:0] tx_ctl_q;
  logic [7:0] rx_ctl_q;
  logic [1:0] ie_q;
  logic [8:0] hold_q;
  logic       hold_full_q;
  logic [7:0] rx_buf_q;
  logic       rx_ninth_q;
  logic       rx_full_q;
  logic       overrun_q;
  logic       ack_q;

  logic [8:0] tsr_q;
  logic       tsr_full_q;
  logic       tx_clr_q;
  logic       rx_clr_q;

  // Link-domain state.
  logic [3:0] tx_cnt_q;
  logic       tx_tgl_q;
  logic [8:0] rsr_q;
  logic [3:0] rx_cnt_q;
  logic [8:0] rx_word_q;
  logic       rx_tgl_q;

  // Core-domain synchronisers.
  logic [2:0] tx_tgl_s_q;
  logic [2:0] rx_tgl_s_q;

  wire serial_port_enable     = rx_ctl_q[`USS_RX_SERIAL_PORT_ENABLE_BIT];
  wire continuous_receive_enable     = rx_ctl_q[`USS_RX_CONTINUOUS_RECEIVE_ENABLE_BIT];
  wire transmit_enable_bit     = tx_ctl_q[`USS_TX_ENABLE_BIT];
  wire slave_md = !tx_ctl_q[`USS_TX_CLOCK_SOURCE_SELECT_BIT] && tx_ctl_q[`USS_TX_SYNC_BIT];
  wire wr       = avs_write && ack_q;
  wire rd       = avs_read && ack_q;
  wire rd_lat   = avs_read && !ack_q;
  wire tx_done  = tx_tgl_s_q[2] ^ tx_tgl_s_q[1];
  wire rx_done  = rx_tgl_s_q[2] ^ rx_tgl_s_q[1];
  wire tx_nine  = tx_ctl_q[`USS_TX_NINTH_OPT];
  wire rx_nine  = rx_ctl_q[`USS_RX_NINTH_OPT];

  // One wait state: answer comes the cycle after a request is seen.
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      tx_ctl_q <= `USS_TX_STATUS_RST;
      rx_ctl_q <= `USS_RX_STATUS_RST;
      ie_q     <= 2'b00;
    end else if (wr) begin
      case (avs_address)
        `USS_OFF_TX_STATUS: begin
          tx_ctl_q <= {avs_writedata[7:4], 3'b000, avs_writedata[0]};
        end
        `USS_OFF_RX_STATUS: begin
          rx_ctl_q <= {avs_writedata[7:6], 1'b0, avs_writedata[4], 4'h0};
        end
        `USS_OFF_IRQ_ENABLE: begin
          ie_q <= avs_writedata[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Holding register: written by software, emptied into the shift word.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      hold_q      <= 9'h000;
      hold_full_q <= 1'b0;
    end else begin
      if (wr && avs_address == `USS_OFF_TX_HOLD) begin
        hold_q      <= {tx_ctl_q[`USS_TX_NINTH_VAL], avs_writedata[7:0]};
        hold_full_q <= 1'b1;
      end else if (hold_full_q && !tsr_full_q && transmit_enable_bit && serial_port_enable && slave_md) begin
        hold_full_q <= 1'b0;
      end
    end
  end

  // Shift word: loaded only while the link owns no word, so it never changes
  // under the shifter; released when the link reports the last bit gone.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      tsr_q      <= 9'h1ff;
      tsr_full_q <= 1'b0;
    end else if (tsr_full_q) begin
      if (tx_done || !serial_port_enable || !slave_md) begin
        tsr_full_q <= 1'b0;
      end
    end else if (hold_full_q && transmit_enable_bit && serial_port_enable && slave_md) begin
      tsr_q      <= hold_q;
      tsr_full_q <= 1'b1;
    end
  end

  // Registered clears for the link side. They reset the link flops asynchronously,
  // so the clears act at once rather than waiting for link edges.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      tx_clr_q <= 1'b1;
      rx_clr_q <= 1'b1;
    end else begin
      tx_clr_q <= !(serial_port_enable && slave_md);
      rx_clr_q <= !(continuous_receive_enable && serial_port_enable && slave_md);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      tx_tgl_s_q <= 3'b000;
      rx_tgl_s_q <= 3'b000;
    end else begin
      tx_tgl_s_q <= {tx_tgl_s_q[1:0], tx_tgl_q};
      rx_tgl_s_q <= {rx_tgl_s_q[1:0], rx_tgl_q};
    end
  end

  // Receive buffer; a new word wins over a read that clears the flag.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rx_buf_q   <= 8'h00;
      rx_ninth_q <= 1'b0;
      rx_full_q  <= 1'b0;
      overrun_q  <= 1'b0;
    end else begin
      if (rx_done && continuous_receive_enable && serial_port_enable) begin
        rx_buf_q   <= rx_word_q[7:0];
        rx_ninth_q <= rx_nine ? rx_word_q[8] : 1'b0;
        rx_full_q  <= 1'b1;
        if (rx_full_q && !(rd && avs_address == `USS_OFF_RX_BUF)) begin
          overrun_q <= 1'b1;
        end
      end else if (rd && avs_address == `USS_OFF_RX_BUF) begin
        rx_full_q <= 1'b0;
      end
      if (!continuous_receive_enable || !serial_port_enable) begin
        overrun_q <= 1'b0;
      end
    end
  end

  assign wake_irq_out = (ie_q[`USS_IE_TX_BIT] && !hold_full_q) ||
                        (ie_q[`USS_IE_RX_BIT] && rx_full_q);

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_lat) begin
      case (avs_address)
        `USS_OFF_TX_STATUS:  avs_readdata <= {24'h0, tx_ctl_q[7:2], !hold_full_q,
                                              tx_ctl_q[0]};
        `USS_OFF_RX_STATUS:  avs_readdata <= {24'h0, rx_ctl_q[7:4], 2'b00,
                                              overrun_q, rx_ninth_q};
        `USS_OFF_RX_BUF:     avs_readdata <= {24'h0, rx_buf_q};
        `USS_OFF_IRQ_ENABLE: avs_readdata <= {30'h0, ie_q};
        default:             avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Transmit bit counter, clocked only by the master's shift clock; it moves to
  // the next bit on each falling edge and reports the end of a word.
  always_ff @(negedge link.shift_clk or posedge tx_clr_q) begin
    if (tx_clr_q) begin
      tx_cnt_q <= 4'h0;
      tx_tgl_q <= 1'b0;
    end else if (tx_cnt_q == (tx_nine ? 4'h8 : 4'h7)) begin
      tx_cnt_q <= 4'h0;
      tx_tgl_q <= !tx_tgl_q;
    end else begin
      tx_cnt_q <= tx_cnt_q + 4'h1;
    end
  end

  // The first bit stands before the first rising edge of a word.
  assign link.slave_data      = tsr_full_q ? tsr_q[tx_cnt_q] : 1'b1;
  assign link.slave_data_oe_n = !tsr_full_q;

  // Receive shifter: samples on rising edges, aborts when disabled.
  always_ff @(posedge link.shift_clk or posedge rx_clr_q) begin
    if (rx_clr_q) begin
      rsr_q     <= 9'h000;
      rx_cnt_q  <= 4'h0;
      rx_word_q <= 9'h000;
      rx_tgl_q  <= 1'b0;
    end else begin
      if (rx_cnt_q == (rx_nine ? 4'h8 : 4'h7)) begin
        rx_word_q <= rx_nine ? {link.data_wire, rsr_q[8:1]}
                             : {1'b0, link.data_wire, rsr_q[8:2]};
        rx_tgl_q  <= !rx_tgl_q;
        rx_cnt_q  <= 4'h0;
      end else begin
        rx_cnt_q  <= rx_cnt_q + 4'h1;
      end
      rsr_q <= {link.data_wire, rsr_q[8:1]};
    end
  end
endmodule

// ==== src/uss_regs.svh ====
// Register offsets, field positions, reset values and timing counts for the sync slave port.
`ifndef USS_REGS_SVH
`define USS_REGS_SVH
`define USS_ADDR_W          3
`define USS_OFF_TX_STATUS   3'h0
`define USS_OFF_RX_STATUS   3'h1
`define USS_OFF_TX_HOLD     3'h2
`define USS_OFF_RX_BUF      3'h3
`define USS_OFF_IRQ_ENABLE  3'h4
`define USS_TX_CLOCK_SOURCE_SELECT_BIT     7
`define USS_TX_NINTH_OPT    6
`define USS_TX_ENABLE_BIT   5
`define USS_TX_SYNC_BIT     4
`define USS_TX_EMPTY_BIT    1
`define USS_TX_NINTH_VAL    0
`define USS_RX_SERIAL_PORT_ENABLE_BIT     7
`define USS_RX_NINTH_OPT    6
`define USS_RX_SINGLE_RECEIVE_ENABLE_BIT     5
`define USS_RX_CONTINUOUS_RECEIVE_ENABLE_BIT     4
`define USS_RX_OVERRUN_BIT  1
`define USS_RX_NINTH_VAL    0
`define USS_IE_TX_BIT       1
`define USS_IE_RX_BIT       0
`define USS_TX_STATUS_RST   8'h02
`define USS_RX_STATUS_RST   8'h00
`define USS_HOST_DIV        4'h2
`endif

// ==== src/uss_pkg.sv ====
// Types for the shift-clock master of the sync slave port.
package uss_pkg;
  typedef logic [8:0] uss_word_t;
  typedef enum logic [2:0] {
    USS_M_IDLE = 3'b001,
    USS_M_SHIFT = 3'b010,
    USS_M_DONE = 3'b100
  } uss_mstate_e;
endpackage

// ==== src/uss_link_if.sv ====
// Link between the external shift-clock master and the sync slave serial port.
`timescale 1ns/1ps
interface uss_link_if;
  logic shift_clk;
  logic slave_data;
  logic slave_data_oe_n;
  logic master_data;
  logic master_data_oe_n;
  logic data_wire;
  assign data_wire = !slave_data_oe_n ? slave_data :
                     (!master_data_oe_n ? master_data : 1'b1);
  modport device (
    input  shift_clk,
    input  data_wire,
    output slave_data,
    output slave_data_oe_n
  );
  modport master (
    output shift_clk,
    input  data_wire,
    output master_data,
    output master_data_oe_n
  );
endinterface

// ==== src/uss_master.sv ====
// External sync master: makes the shift clock and shifts words with the slave.
`timescale 1ns/1ps
`include "uss_regs.svh"
module uss_master (
  input  wire logic                    core_clk_in,
  input  wire logic                    reset_in,
  input  wire logic                    start_in,
  input  wire logic                    drive_in,
  input  wire logic [8:0]              word_in,
  input  wire logic                    nine_in,
  output logic                         busy_out,
  output logic                         done_out,
  output logic      [8:0]              word_out,
  uss_link_if.master                   link
);
  uss_pkg::uss_mstate_e state_q;
  logic [3:0] div_q;
  logic       clk_q;
  logic [3:0] bits_q;
  logic [8:0] tx_q;
  logic [8:0] rx_q;
  logic       drv_q;
  logic       nine_q;

  assign link.shift_clk        = clk_q;
  assign link.master_data      = tx_q[0];
  assign link.master_data_oe_n = !(drv_q && state_q == uss_pkg::USS_M_SHIFT);
  assign busy_out              = state_q != uss_pkg::USS_M_IDLE;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_q  <= uss_pkg::USS_M_IDLE;
      div_q    <= 4'h0;
      clk_q    <= 1'b0;
      bits_q   <= 4'h0;
      tx_q     <= 9'h1ff;
      rx_q     <= 9'h000;
      drv_q    <= 1'b0;
      nine_q   <= 1'b0;
      done_out <= 1'b0;
      word_out <= 9'h000;
    end else begin
      done_out <= 1'b0;
      case (state_q)
        uss_pkg::USS_M_IDLE: begin
          if (start_in) begin
            tx_q    <= word_in;
            drv_q   <= drive_in;
            nine_q  <= nine_in;
            bits_q  <= nine_in ? 4'h9 : 4'h8;
            div_q   <= 4'h0;
            state_q <= uss_pkg::USS_M_SHIFT;
          end
        end
        uss_pkg::USS_M_SHIFT: begin
          if (div_q == `USS_HOST_DIV - 4'h1) begin
            div_q <= 4'h0;
            clk_q <= !clk_q;
            if (!clk_q) begin
              rx_q <= {link.data_wire, rx_q[8:1]};
            end else begin
              tx_q   <= {1'b1, tx_q[8:1]};
              bits_q <= bits_q - 4'h1;
              if (bits_q == 4'h1) begin
                state_q <= uss_pkg::USS_M_DONE;
              end
            end
          end else begin
            div_q <= div_q + 4'h1;
          end
        end
        uss_pkg::USS_M_DONE: begin
          word_out <= nine_q ? rx_q : {1'b0, rx_q[8:1]};
          done_out <= 1'b1;
          state_q  <= uss_pkg::USS_M_IDLE;
        end
        default: begin
          state_q <= uss_pkg::USS_M_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== verification/uss_link_chk.sv ====
// Link-side checks for the sync slave port and its shift-clock master.
`timescale 1ns/1ps
module uss_link_chk (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic shift_clk,
  input wire logic slave_data,
  input wire logic slave_data_oe_n,
  input wire logic master_data,
  input wire logic master_data_oe_n,
  input wire logic data_wire
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  slv_fall_a: assert property (!slave_data_oe_n && $past(!slave_data_oe_n)
    && $changed(slave_data) |-> $fell(shift_clk)) else $error("slave data moved off fall");
  mst_rise_a: assert property ($rose(shift_clk) && !master_data_oe_n
    && $past(!master_data_oe_n) |-> $stable(master_data)) else $error("master data moved");
  clk_high_a: assert property ($rose(shift_clk) |=> shift_clk ##1 !shift_clk)
    else $error("shift clock high phase wrong");
  clk_low_a: assert property ($fell(shift_clk) |=> !shift_clk)
    else $error("shift clock low phase short");
  one_drv_a: assert property (!(!slave_data_oe_n && !master_data_oe_n))
    else $error("both ends drive the data line");
  wire_idle_a: assert property (slave_data_oe_n && master_data_oe_n |-> data_wire)
    else $error("released data line not high");
  wire_slv_a: assert property (!slave_data_oe_n |-> data_wire == slave_data)
    else $error("data line differs from slave drive");
  wire_mst_a: assert property (slave_data_oe_n && !master_data_oe_n |-> data_wire == master_data)
    else $error("data line differs from master drive");
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench: slave and master joined over the link, driven by register calls.
`timescale 1ns/1ps
`include "uss_regs.svh"
module tb_top;
  logic        core_clk_in, reset_in, avs_read, avs_write, avs_waitrequest, wake_irq_out;
  logic [2:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic        start_q, drive_q, nine_q, busy, done;
  logic [8:0]  word_q, word_got;
  logic [7:0]  rd;
  int          errors, check_count;
  uss_link_if i_uss_link_if();
  uss_slave i_uss_slave(.core_clk_in, .reset_in, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .wake_irq_out, .link(i_uss_link_if));
  uss_master i_uss_master(.core_clk_in, .reset_in, .start_in(start_q), .drive_in(drive_q),
    .word_in(word_q), .nine_in(nine_q), .busy_out(busy), .done_out(done),
    .word_out(word_got), .link(i_uss_link_if));
  uss_link_chk i_uss_link_chk(.core_clk_in, .reset_in, .shift_clk(i_uss_link_if.shift_clk),
    .slave_data(i_uss_link_if.slave_data), .slave_data_oe_n(i_uss_link_if.slave_data_oe_n),
    .master_data(i_uss_link_if.master_data), .data_wire(i_uss_link_if.data_wire),
    .master_data_oe_n(i_uss_link_if.master_data_oe_n));
  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end
  task automatic test_done();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk_in);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge core_clk_in);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) errors++;
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check({24'h0, rd}, {24'h0, e});
  endtask
  // Runs one master frame; start is a one-cycle pulse, then the task waits for done and checks busy low.
  task automatic xfer(input logic dr, input logic [8:0] w, input logic n9);
    int n;
    n = 0;
    @(posedge core_clk_in);
    start_q <= 1'b1;
    drive_q <= dr;
    word_q <= w;
    nine_q <= n9;
    @(posedge core_clk_in);
    start_q <= 1'b0;
    while (done !== 1'b1 && n < 200) begin
      @(posedge core_clk_in);
      n++;
    end
    if (n >= 200) errors++;
    check({31'h0, busy}, 32'h0);
  endtask
  initial begin
    repeat (20000) @(posedge core_clk_in);
    errors++;
    test_done();
  end
  initial begin
    {errors, check_count} = '0;
    {reset_in, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 37'h0};
    {start_q, drive_q, word_q, nine_q} = '0;
    repeat (16) @(posedge core_clk_in);
    reset_in <= 1'b0;
    rdchk(`USS_OFF_TX_STATUS, `USS_TX_STATUS_RST);
    rdchk(`USS_OFF_RX_STATUS, `USS_RX_STATUS_RST);
    rdchk(3'h7, 8'h00);
    $display("reset test end");
    bus(1'b1, `USS_OFF_RX_STATUS, 8'h80);
    bus(1'b1, `USS_OFF_TX_STATUS, 8'h10);
    bus(1'b1, `USS_OFF_IRQ_ENABLE, 8'h02);
    @(posedge core_clk_in);
    check({31'h0, wake_irq_out}, 32'h1);
    bus(1'b1, `USS_OFF_TX_HOLD, 8'h4b);
    bus(1'b1, `USS_OFF_TX_STATUS, 8'h30);
    bus(1'b1, `USS_OFF_TX_HOLD, 8'h1e);
    repeat (20) @(posedge core_clk_in);
    rdchk(`USS_OFF_TX_STATUS, 8'h30);
    check({31'h0, wake_irq_out}, 32'h0);
    xfer(1'b0, 9'h000, 1'b0);
    check({23'h0, word_got}, 32'h04b);
    xfer(1'b0, 9'h000, 1'b0);
    check({23'h0, word_got}, 32'h01e);
    repeat (20) @(posedge core_clk_in);
    rdchk(`USS_OFF_TX_STATUS, 8'h32);
    check({31'h0, wake_irq_out}, 32'h1);
    bus(1'b1, `USS_OFF_TX_STATUS, 8'h71);
    bus(1'b1, `USS_OFF_TX_HOLD, 8'h35);
    repeat (20) @(posedge core_clk_in);
    xfer(1'b0, 9'h000, 1'b1);
    check({23'h0, word_got}, 32'h135);
    $display("transmit test end");
    bus(1'b1, `USS_OFF_TX_STATUS, 8'h10);
    bus(1'b1, `USS_OFF_IRQ_ENABLE, 8'h01);
    bus(1'b1, `USS_OFF_RX_STATUS, 8'hf0);
    rdchk(`USS_OFF_RX_STATUS, 8'hd0);
    xfer(1'b1, 9'h1c1, 1'b1);
    repeat (20) @(posedge core_clk_in);
    check({31'h0, wake_irq_out}, 32'h1);
    rdchk(`USS_OFF_RX_STATUS, 8'hd1);
    rdchk(`USS_OFF_RX_BUF, 8'hc1);
    @(posedge core_clk_in);
    check({31'h0, wake_irq_out}, 32'h0);
    $display("receive test end");
    xfer(1'b1, 9'h011, 1'b1);
    xfer(1'b1, 9'h022, 1'b1);
    repeat (20) @(posedge core_clk_in);
    rdchk(`USS_OFF_RX_STATUS, 8'hd2);
    bus(1'b1, `USS_OFF_RX_STATUS, 8'hc0);
    rdchk(`USS_OFF_RX_STATUS, 8'hc0);
    bus(1'b0, `USS_OFF_RX_BUF, 8'h00);
    bus(1'b1, `USS_OFF_RX_STATUS, 8'hd0);
    fork
      xfer(1'b1, 9'h0ff, 1'b1);
      begin
        repeat (12) @(posedge core_clk_in);
        bus(1'b1, `USS_OFF_RX_STATUS, 8'hc0);
      end
    join
    bus(1'b1, `USS_OFF_RX_STATUS, 8'hd0);
    xfer(1'b1, 9'h0a6, 1'b1);
    repeat (20) @(posedge core_clk_in);
    rdchk(`USS_OFF_RX_BUF, 8'ha6);
    $display("error and abort test end");
    test_done();
  end
endmodule
